// file: inc/cigm_regs.vh
// Purpose: register offsets, field positions and reset values for the
//          interrupt gating and machine-check slice
// Assumes: 32-bit registers, one aligned word per register
// Notes:   included by logic/cigm_top.v
`ifndef CIGM_REGS_VH
`define CIGM_REGS_VH

// ==========================================================================
// register byte offsets
`define CIGM_OFF_PREFIX     8'h00
`define CIGM_OFF_MSTATE     8'h04
`define CIGM_OFF_ESR        8'h08
`define CIGM_OFF_MCHECK_SYNDROME_REG       8'h0C
`define CIGM_OFF_TCR        8'h10
`define CIGM_OFF_IRQ_STAT   8'h14
`define CIGM_OFF_IRQ_MASK   8'h18
`define CIGM_OFF_VEC_OUT    8'h1C
`define CIGM_OFF_IVO_BASE   8'h40

// ==========================================================================
// machine state register bit positions
`define CIGM_MS_WE          18
`define CIGM_MS_CE          17
`define CIGM_MS_EE          15
`define CIGM_MS_ME          12
`define CIGM_MS_FE0         11
`define CIGM_MS_DE          9
`define CIGM_MS_FE1         8

// syndrome and timer control bit positions
`define CIGM_ESR_MCI        0
`define CIGM_MCHECK_SYNDROME_REG_MCS       0
`define CIGM_TCR_WRE        29

// ==========================================================================
// reset values
`define CIGM_RST_WORD       32'h0000_0000
`define CIGM_RST_MSTATE     32'h0000_0000

// interrupt status bits: taken, parity mcheck, wake
`define CIGM_IRQ_TAKEN      0
`define CIGM_IRQ_PARITY     1
`define CIGM_IRQ_WAKE       2

`endif

// file: logic/cigm_top.v
// Purpose: interrupt gating, vector formation and machine-check status
// Assumes: all inputs synchronous to clk_sys_in
// Notes:   source ids 0..15 select the vector offset register used
//
// Function
// - low four bits of vector offsets ignored on write, zero on use
// - handler address high part comes from the vector prefix register
// - critical input and watchdog interrupts gated by critical enable
// - external, decrementer and fixed interval gated by external enable
// - debug interrupts gated by debug interrupt enable
// - with machine check enable set, machine checks become interrupts
// - machine check sets sticky flags even when disabled; software clears
// - reset clears syndrome and summary machine-check flags
// - watchdog reset enable cannot be cleared once set except by reset
// - cache parity errors vector to the machine check handler
// - wait state halts execution until an interrupt is taken
// - fp enabled program interrupts gated by the two fp mode bits
//
// ==========================================================================
// register map
//   0x00 vector prefix, upper half kept, lower half reads zero
//   0x04 machine state: wait, critical, external, mcheck, fp, debug enables
//   0x08 exception syndrome, write replaces, hardware mcheck bit wins
//   0x0C mcheck syndrome, write one to clear, hardware sets win
//   0x10 timer control, watchdog reset enable sticky until reset
//   0x14 interrupt status, write one to clear: taken, parity, wake
//   0x18 interrupt mask, same layout as status
//   0x1C last handler address, read only
//   0x40 sixteen vector offset words, one per source class
//
// hazards
//   a parity error only vectors while machine checks are enabled;
//   otherwise it is remembered in the syndrome bits for software
//   a set and a clear of one status bit in the same cycle keep the set,
//   so an event is never lost behind a software clear
//
// The address map and the plain strobed port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "cigm_regs.vh"

module cigm_top #(
    parameter AW = 8                          // register address width
) (
    input  wire          clk_sys_in,          // core clock
    input  wire          rst_b_in,            // async reset, active low
    input  wire [AW-1:0] addr_in,             // register byte address
    input  wire [31:0]   wdata_in,            // register write data
    input  wire          wr_in,               // write strobe
    input  wire          rd_in,               // read strobe
    input  wire          crit_in,             // critical input request
    input  wire          wdog_in,             // watchdog timer exception
    input  wire          ext_in,              // external input request
    input  wire          dec_in,              // decrementer exception
    input  wire          fit_in,              // fixed interval timer exception
    input  wire          dbg_in,              // debug event
    input  wire          mchk_in,             // machine check exception
    input  wire          icache_par_in,       // icache parity error
    input  wire          dcache_par_in,       // dcache parity error
    input  wire          fp_exc_in,           // fp enabled exception
    output reg  [31:0]   rdata_out,           // read data, cycle after read
    output reg           take_out,            // interrupt taken, high the cycle after each cycle with an enabled request
    output reg  [31:0]   vector_out,          // handler address
    output reg           halt_out,            // instruction execution halted
    output reg           wdog_rst_en_out,     // watchdog reset enabled
    output reg           irq_out              // level interrupt to software
);

    // ======================================================================
    // class indices into the vector offset registers
    localparam [3:0] V_CRIT = 4'h0;
    localparam [3:0] V_MCHK = 4'h1;
    localparam [3:0] V_EXT  = 4'h4;
    localparam [3:0] V_PROG = 4'h6;
    localparam [3:0] V_DEC  = 4'hA;
    localparam [3:0] V_FIT  = 4'hB;
    localparam [3:0] V_WDOG = 4'hC;
    localparam [3:0] V_DBG  = 4'hF;

    // ======================================================================
    // state
    reg  [31:0] vector_prefix_reg;
    reg  [27:0] vector_offset_regs [0:15];    // bits 31:4 only
    reg  [31:0] machine_state_reg;
    reg  [31:0] exception_syndrome_reg;
    reg  [31:0] mcheck_syndrome_reg;
    reg  [31:0] timer_control_reg;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    integer     i;

    wire wr_pref  = wr_in && addr_in == `CIGM_OFF_PREFIX;
    wire wr_ms    = wr_in && addr_in == `CIGM_OFF_MSTATE;
    wire wr_esr   = wr_in && addr_in == `CIGM_OFF_ESR;
    wire wr_mcheck_syndrome_reg  = wr_in && addr_in == `CIGM_OFF_MCHECK_SYNDROME_REG;
    wire wr_tcr   = wr_in && addr_in == `CIGM_OFF_TCR;
    wire wr_stat  = wr_in && addr_in == `CIGM_OFF_IRQ_STAT;
    wire wr_mask  = wr_in && addr_in == `CIGM_OFF_IRQ_MASK;
    wire ivo_hit  = addr_in[AW-1:6] == (`CIGM_OFF_IVO_BASE >> 6);
    wire [3:0] ivo_idx = addr_in[5:2];

    // handler address: prefix upper half, offset lower half
    function [31:0] hand_addr;
        input [31:0] pref;
        input [27:0] off;
        begin
            hand_addr = {pref[31:16], off[11:0], 4'h0};
        end
    endfunction

    // ======================================================================
    // request gating by machine state enables
    wire ce  = machine_state_reg[`CIGM_MS_CE];
    wire ee  = machine_state_reg[`CIGM_MS_EE];
    wire de  = machine_state_reg[`CIGM_MS_DE];
    wire me  = machine_state_reg[`CIGM_MS_ME];
    wire fpm = machine_state_reg[`CIGM_MS_FE0] |
               machine_state_reg[`CIGM_MS_FE1];
    wire par = icache_par_in | dcache_par_in;
    wire mchk_any = mchk_in | par;
    wire g_mchk = mchk_any & me;
    wire g_crit = crit_in & ce;
    wire g_wdog = wdog_in & ce;
    wire g_ext  = ext_in & ee;
    wire g_dec  = dec_in & ee;
    wire g_fit  = fit_in & ee;
    wire g_dbg  = dbg_in & de;
    wire g_prog = fp_exc_in & fpm;

    // priority select: machine check first, debug last
    reg       next_take;
    reg [3:0] next_sel;
    always @* begin
        next_take = 1'b1;
        next_sel  = V_MCHK;
        if (g_mchk) begin
            next_sel = V_MCHK;
        end else if (g_crit) begin
            next_sel = V_CRIT;
        end else if (g_wdog) begin
            next_sel = V_WDOG;
        end else if (g_ext) begin
            next_sel = V_EXT;
        end else if (g_prog) begin
            next_sel = V_PROG;
        end else if (g_dec) begin
            next_sel = V_DEC;
        end else if (g_fit) begin
            next_sel = V_FIT;
        end else if (g_dbg) begin
            next_sel = V_DBG;
        end else begin
            next_take = 1'b0;
        end
    end

    // ======================================================================
    // mcheck syndrome next value: clear first, then hardware sets on top
    // so a clear of one bit never undoes an unrelated or same-cycle set
    reg [31:0] next_mcheck_syndrome_reg;
    always @* begin
        next_mcheck_syndrome_reg = mcheck_syndrome_reg;
        if (wr_mcheck_syndrome_reg) begin
            next_mcheck_syndrome_reg = next_mcheck_syndrome_reg & ~wdata_in;
        end
        if (mchk_any) begin
            next_mcheck_syndrome_reg[`CIGM_MCHECK_SYNDROME_REG_MCS] = 1'b1;
            next_mcheck_syndrome_reg[1] = next_mcheck_syndrome_reg[1] | icache_par_in;
            next_mcheck_syndrome_reg[2] = next_mcheck_syndrome_reg[2] | dcache_par_in;
        end
    end

    // ======================================================================
    // registers written by software; hardware sets win over clears
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            vector_prefix_reg      <= `CIGM_RST_WORD;
            machine_state_reg      <= `CIGM_RST_MSTATE;
            exception_syndrome_reg <= `CIGM_RST_WORD;
            mcheck_syndrome_reg    <= `CIGM_RST_WORD;
            timer_control_reg      <= `CIGM_RST_WORD;
            irq_stat               <= 3'h0;
            irq_mask               <= 3'h0;
            for (i = 0; i < 16; i = i + 1) begin
                vector_offset_regs[i] <= 28'h0000000;
            end
        end else begin
            if (wr_pref) begin
                vector_prefix_reg <= {wdata_in[31:16], 16'h0000};
            end
            if (wr_in && ivo_hit) begin
                vector_offset_regs[ivo_idx] <= wdata_in[31:4];
            end
            // wait bit drops when an interrupt is taken
            if (wr_ms) begin
                machine_state_reg <= wdata_in;
            end else if (next_take) begin
                machine_state_reg[`CIGM_MS_WE] <= 1'b0;
            end
            // syndrome flags: only software writes clear them
            if (wr_esr) begin
                exception_syndrome_reg <= wdata_in;
            end
            if (mchk_any) begin
                exception_syndrome_reg[`CIGM_ESR_MCI] <= 1'b1;
            end
            mcheck_syndrome_reg <= next_mcheck_syndrome_reg;
            // watchdog reset enable is sticky until reset
            if (wr_tcr) begin
                timer_control_reg <= wdata_in |
                    (timer_control_reg & (32'h1 << `CIGM_TCR_WRE));
            end
            if (wr_mask) begin
                irq_mask <= wdata_in[2:0];
            end
            irq_stat <= (irq_stat & ~({3{wr_stat}} & wdata_in[2:0])) |
                        {machine_state_reg[`CIGM_MS_WE] & next_take,
                         par, next_take};
        end
    end

    // ======================================================================
    // outputs and read port, all registered
    always @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out       <= 32'h0000_0000;
            take_out        <= 1'b0;
            vector_out      <= 32'h0000_0000;
            halt_out        <= 1'b0;
            wdog_rst_en_out <= 1'b0;
            irq_out         <= 1'b0;
        end else begin
            take_out   <= next_take;
            if (next_take) begin
                vector_out <= hand_addr(vector_prefix_reg,
                                        vector_offset_regs[next_sel]);
            end
            halt_out <= machine_state_reg[`CIGM_MS_WE] & ~next_take;
            wdog_rst_en_out <= timer_control_reg[`CIGM_TCR_WRE];
            irq_out  <= |(irq_stat & irq_mask);
            rdata_out <= 32'h0000_0000;
            if (rd_in) begin
                if (ivo_hit) begin
                    rdata_out <= {vector_offset_regs[ivo_idx], 4'h0};
                end else begin
                    case (addr_in)
                        `CIGM_OFF_PREFIX:   rdata_out <= vector_prefix_reg;
                        `CIGM_OFF_MSTATE:   rdata_out <= machine_state_reg;
                        `CIGM_OFF_ESR:      rdata_out <= exception_syndrome_reg;
                        `CIGM_OFF_MCHECK_SYNDROME_REG:     rdata_out <= mcheck_syndrome_reg;
                        `CIGM_OFF_TCR:      rdata_out <= timer_control_reg;
                        `CIGM_OFF_IRQ_STAT: rdata_out <= {29'h0, irq_stat};
                        `CIGM_OFF_IRQ_MASK: rdata_out <= {29'h0, irq_mask};
                        `CIGM_OFF_VEC_OUT:  rdata_out <= vector_out;
                        default:            rdata_out <= 32'h0000_0000;
                    endcase
                end
            end
        end
    end

endmodule // cigm_top
`default_nettype wire

// file: dv/cigm_src.sv
// Purpose: model of the interrupt sources and timers
// Assumes: each source holds its level until told to drop it
// Notes:   bits crit wdog ext dec fit dbg mchk icpar dcpar fp
`timescale 1ns/10ps
`default_nettype none
module cigm_src (
    input  wire logic       clk_in,   // core clock
    input  wire logic       rst_b_in, // async reset, active low
    input  wire logic [9:0] set_in,   // raise sources
    input  wire logic [9:0] clr_in,   // drop sources
    output logic      [9:0] ev_out    // source levels
);
    // ======================================================
    // levels, not pulses: real lines stay up until serviced
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in)
            ev_out <= 10'h000;
        else
            ev_out <= (ev_out | set_in) & ~clr_in;
    end
endmodule // cigm_src
`default_nettype wire

// file: dv/cigm_chk.sv
// Purpose: port checks of interrupt gating and vector forming
// Assumes: machine state enables change only by register writes; the wait bit also drops when an interrupt is taken
// Notes:   shadow registers mirror what software wrote
`timescale 1ns/10ps
`default_nettype none
`include "cigm_regs.vh"
module cigm_chk #(parameter AW = 8) (
    input wire logic clk_sys_in, rst_b_in, wr_in, rd_in, // bus
    input wire logic [AW-1:0] addr_in,                   // address
    input wire logic [31:0] wdata_in, rdata_out, vector_out, // data
    input wire logic crit_in, wdog_in, ext_in, dec_in, fit_in, // events
    input wire logic dbg_in, mchk_in, icache_par_in, dcache_par_in,
    input wire logic fp_exc_in, take_out, halt_out, wdog_rst_en_out
);
    logic [31:0] ms;
    logic [15:0] ph;
    logic [11:0] vo1;
    logic        mce, en;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_b_in);
    // ======================================================
    // shadows of machine state, prefix and mcheck offset
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ms <= 32'h0;
            ph <= 16'h0;
            vo1 <= 12'h0;
        end else if (wr_in) begin
            if (addr_in == `CIGM_OFF_MSTATE) ms <= wdata_in;
            if (addr_in == `CIGM_OFF_PREFIX) ph <= wdata_in[31:16];
            if (addr_in == 8'h44) vo1 <= wdata_in[15:4];
        end
    end
    // enabled request as seen by software state
    assign mce = ms[`CIGM_MS_ME] & (mchk_in | icache_par_in | dcache_par_in);
    assign en = mce | ms[`CIGM_MS_CE] & (crit_in | wdog_in)
        | ms[`CIGM_MS_EE] & (ext_in | dec_in | fit_in)
        | ms[`CIGM_MS_DE] & dbg_in
        | (ms[`CIGM_MS_FE0] | ms[`CIGM_MS_FE1]) & fp_exc_in;
    // ======================================================
    a_take_gated: assert property (
        take_out |-> $past(en))
        else $error("interrupt taken while gated off");
    a_take_fires: assert property (en |=> take_out)
        else $error("enabled request not taken");
    a_vec_align: assert property (take_out |-> vector_out[3:0] == 4'h0)
        else $error("vector low bits not zero");
    a_vec_prefix: assert property (take_out |->
        vector_out[31:16] == $past(ph))
        else $error("vector high half not from prefix");
    a_mchk_vector: assert property (take_out && $past(mce) |->
        vector_out[15:4] == $past(vo1))
        else $error("machine check vector wrong");
    a_wdog_sticky: assert property (
        $past(wdog_rst_en_out) |-> wdog_rst_en_out)
        else $error("watchdog reset enable dropped");
    a_halt_wakes: assert property (take_out |-> ##[0:1] !halt_out)
        else $error("still halted after interrupt");
    a_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
        else $error("read data outside read cycle");
endmodule // cigm_chk
bind cigm_top cigm_chk #(.AW(AW)) u_chk (.clk_sys_in, .rst_b_in,
    .wr_in, .rd_in, .addr_in, .wdata_in, .rdata_out, .vector_out,
    .crit_in, .wdog_in, .ext_in, .dec_in, .fit_in, .dbg_in, .mchk_in,
    .icache_par_in, .dcache_par_in, .fp_exc_in, .take_out, .halt_out,
    .wdog_rst_en_out);
`default_nettype wire

// file: dv/tb.sv
// Purpose: register-level tests of gating, vectors and mcheck status
// Assumes: prefix and offsets written before any event
// Notes:   each task ends just after a rising edge
`timescale 1ns/10ps
`default_nettype none
`include "cigm_regs.vh"
module tb;
    logic clk_sys_in = 1'b0, rst_b_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [7:0]  addr_in = 8'h00;
    logic [31:0] wdata_in = 32'h0, rdata_out, vector_out, v, e;
    logic        take_out, halt_out, wdog_rst_en_out, irq_out;
    logic [9:0]  set_v = 10'h0, clr_v = 10'h0, ev;
    int n_fail = 0, n_compared = 0;
    int en_b [10] = '{`CIGM_MS_CE, `CIGM_MS_CE, `CIGM_MS_EE, `CIGM_MS_EE,
        `CIGM_MS_EE, `CIGM_MS_DE, `CIGM_MS_ME, `CIGM_MS_ME, `CIGM_MS_ME,
        `CIGM_MS_FE0};
    int vi [10] = '{0, 12, 4, 10, 11, 15, 1, 1, 1, 6};
    cigm_top dut (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
        .rd_in(rd_in), .crit_in(ev[0]), .wdog_in(ev[1]), .ext_in(ev[2]),
        .dec_in(ev[3]), .fit_in(ev[4]), .dbg_in(ev[5]), .mchk_in(ev[6]),
        .icache_par_in(ev[7]), .dcache_par_in(ev[8]), .fp_exc_in(ev[9]),
        .rdata_out(rdata_out), .take_out(take_out),
        .vector_out(vector_out), .halt_out(halt_out),
        .wdog_rst_en_out(wdog_rst_en_out), .irq_out(irq_out));
    cigm_src u_src (.clk_in(clk_sys_in), .rst_b_in(rst_b_in),
        .set_in(set_v), .clr_in(clr_v), .ev_out(ev));
    // ======================================================
    // clock, watchdog and shared tasks
    initial forever #10 clk_sys_in = ~clk_sys_in;
    initial begin
        #200_000;
        n_fail++;
        finish_test;
    end
    function automatic logic [31:0] ofs(int n);
        return 32'h1000 + 32'h110 * n;
    endfunction
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    // one idle cycle after each strobe keeps drivers single per step
    task automatic wr(logic [7:0] a, logic [31:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        tick(1);
        wr_in <= 1'b0;
        tick(1);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] d);
        addr_in <= a;
        rd_in <= 1'b1;
        tick(1);
        rd_in <= 1'b0;
        tick(1);
        d = rdata_out;
    endtask
    task automatic src(logic [9:0] s, logic [9:0] c);
        set_v <= s;
        clr_v <= c;
        tick(1);
        set_v <= 10'h0;
        clr_v <= 10'h0;
        tick(1);
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // ======================================================
    // test sequence
    initial begin
        tick(5);
        rst_b_in <= 1'b1;
        tick(1);
        rd(`CIGM_OFF_ESR, v); chk("esr", v, 32'h0);
        rd(`CIGM_OFF_MCHECK_SYNDROME_REG, v); chk("mcheck_syndrome_reg", v, 32'h0);
        wr(`CIGM_OFF_PREFIX, 32'hABCD_1234);
        rd(`CIGM_OFF_PREFIX, v); chk("prefix", v, 32'hABCD_0000);
        for (int n = 0; n < 16; n++) begin
            wr(8'(8'h40 + 4 * n), ofs(n) | 32'hF);
            rd(8'(8'h40 + 4 * n), v); chk("offset", v, ofs(n));
        end
        // each source first masked, then enabled alone
        for (int i = 0; i < 10; i++) begin
            src(10'(1 << i), 10'h0);
            tick(2);
            chk("masked", take_out, 1'b0);
            wr(`CIGM_OFF_MSTATE, 32'h1 << en_b[i]);
            tick(1);
            chk("taken", take_out, 1'b1);
            chk("vector", vector_out, 32'hABCD_0000 | ofs(vi[i]));
            src(10'h0, 10'(1 << i));
            wr(`CIGM_OFF_MSTATE, 32'h0);
        end
        rd(`CIGM_OFF_ESR, e);
        rd(`CIGM_OFF_MCHECK_SYNDROME_REG, v);
        chk("mcheck_flags", {e[0] | v[0], v[2:1]}, 3'b111);
        wr(`CIGM_OFF_IRQ_MASK, 32'h1); tick(1); chk("irq_on", irq_out, 1'b1);
        wr(`CIGM_OFF_IRQ_MASK, 32'h0); tick(1); chk("irq_off", irq_out, 1'b0);
        wr(`CIGM_OFF_IRQ_MASK, 32'h7);
        wr(`CIGM_OFF_IRQ_STAT, 32'h7); tick(1); chk("irq_clr", irq_out, 1'b0);
        rd(8'h30, v); chk("unmapped", v, 32'h0);
        wr(`CIGM_OFF_TCR, 32'h2000_0000); tick(1);
        chk("wdog_on", wdog_rst_en_out, 1'b1);
        wr(`CIGM_OFF_TCR, 32'h0); tick(1);
        chk("wdog_kept", wdog_rst_en_out, 1'b1);
        rst_b_in <= 1'b0;
        tick(2);
        rst_b_in <= 1'b1;
        tick(1);
        chk("wdog_reset", wdog_rst_en_out, 1'b0);
        rd(`CIGM_OFF_ESR, v); chk("esr_reset", v, 32'h0);
        rd(`CIGM_OFF_MCHECK_SYNDROME_REG, v); chk("mcheck_syndrome_reg_reset", v, 32'h0);
        src(10'h040, 10'h0);
        src(10'h0, 10'h040);
        rd(`CIGM_OFF_ESR, v); chk("mci_off", v[0], 1'b1);
        rd(`CIGM_OFF_MCHECK_SYNDROME_REG, v); chk("mcs_off", v[0], 1'b1);
        wr(`CIGM_OFF_ESR, 32'h0);
        wr(`CIGM_OFF_MCHECK_SYNDROME_REG, 32'hFFFF_FFFF);
        rd(`CIGM_OFF_ESR, v); chk("esr_clr", v, 32'h0);
        rd(`CIGM_OFF_MCHECK_SYNDROME_REG, v); chk("mcheck_syndrome_reg_clr", v, 32'h0);
        wr(`CIGM_OFF_MSTATE, 32'h1 << `CIGM_MS_WE | 32'h1 << `CIGM_MS_EE);
        tick(1);
        chk("halted", halt_out, 1'b1);
        src(10'h004, 10'h0);
        tick(1);
        chk("woken", halt_out, 1'b0);
        rd(`CIGM_OFF_IRQ_STAT, v); chk("wake_stat", v[2], 1'b1);
        finish_test;
    end
endmodule // tb
`default_nettype wire
